// ===== include/canmfc_pkg.sv
// Package for the CAN mode and filter control block.
// Assumes a 32-bit APB register bus, one word per register.
package canmfc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FLT_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_TS_TIMER  = 8'h08;
    localparam logic [7:0] ADDR_TS_STAMP  = 8'h0c;
    // Mode control fields
    localparam int ABORT_BIT   = 27;
    localparam int REQUESTED_OP_MODE_LSB   = 24;
    localparam int STAT_LSB    = 21;
    localparam int CAPEN_BIT   = 20;
    localparam int ON_BIT      = 15;
    localparam int IDLEST_BIT  = 13;
    localparam int BUSY_BIT    = 11;
    localparam int DNCNT_LSB   = 0;
    localparam int DNCNT_W     = 5;
    // Filter byte layout
    localparam int FLT_EN_BIT  = 7;
    localparam int FLT_MS_LSB  = 5;
    localparam int FLT_FS_LSB  = 0;
    localparam int NUM_FLT     = 4;
    localparam int FIRST_FLT   = 8;
    localparam logic [4:0] FIFO_MAX = 5'h0f;
    // Mode encodings
    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'h0,
        MODE_DISABLE  = 3'h1,
        MODE_LOOPBACK = 3'h2,
        MODE_LISTEN   = 3'h3,
        MODE_CONFIG   = 3'h4,
        MODE_RSVD5    = 3'h5,
        MODE_RSVD6    = 3'h6,
        MODE_LISTEN_ALL = 3'h7
    } canmfc_mode_t;
    // Time taken to settle a mode change
    localparam int MODE_SETTLE_NS = 16;
    localparam int CLK_PERIOD_NS  = 4;
    localparam int MODE_SETTLE_CYC =
        (MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : canmfc_pkg

// ===== include/canmfc_flt_if.sv
// Filter configuration carrier between top and filter logic.
// Assumes one clock domain shared by both sides.
interface canmfc_flt_if;
    logic [31:0] wdata;
    logic        we;
    logic [31:0] cfg;
    logic [3:0]  id_hit;
    logic        match;
    logic [1:0]  mask_sel;
    logic [3:0]  fifo_sel;
    logic [1:0]  flt_idx;
    modport ctrl (output wdata, we, id_hit, input cfg, match, mask_sel,
                  fifo_sel, flt_idx);
    modport flt  (input wdata, we, id_hit, output cfg, match, mask_sel,
                  fifo_sel, flt_idx);
endinterface : canmfc_flt_if

// ===== hdl/canmfc_filters.sv
// Acceptance filter control bytes for four filters.
// Assumes writes arrive as whole-word strobes from the register block.
module canmfc_filters (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link to control block
    canmfc_flt_if.flt fl
);
    logic [31:0] cfg_r;
    logic [3:0]  hit_q;
    assign fl.cfg = cfg_r;

    // One byte per filter; first filter in the lowest byte
    for (genvar g = 0; g < canmfc_pkg::NUM_FLT; g++) begin : g_flt
        // RQ12 locked while enabled
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                cfg_r[8*g +: 8] <= 8'h00;
            end else if (fl.we) begin
                // Only the enable bit may move while the filter is live
                if (!cfg_r[8*g + canmfc_pkg::FLT_EN_BIT]) begin
                    cfg_r[8*g +: 8] <= fl.wdata[8*g +: 8];
                end else begin
                    cfg_r[8*g + canmfc_pkg::FLT_EN_BIT] <=
                        fl.wdata[8*g + canmfc_pkg::FLT_EN_BIT];
                end
            end
        end
        // RQ9 enabled filters only
        assign hit_q[g] = fl.id_hit[g] & cfg_r[8*g + canmfc_pkg::FLT_EN_BIT];
    end

    // Lowest numbered live filter wins; reserved FIFO codes refuse
    always_comb begin
        logic [7:0] b;
        b           = 8'h00;
        fl.match    = 1'b0;
        fl.flt_idx  = 2'd0;
        fl.mask_sel = 2'd0;
        fl.fifo_sel = 4'd0;
        for (int i = canmfc_pkg::NUM_FLT - 1; i >= 0; i--) begin
            b = cfg_r[8*i +: 8];
            // RQ11 reserved FIFO codes
            if (hit_q[i] && b[canmfc_pkg::FLT_FS_LSB +: 5] <=
                canmfc_pkg::FIFO_MAX) begin
                fl.match    = 1'b1;
                fl.flt_idx  = 2'(i);
                // RQ10 mask selection
                fl.mask_sel = b[canmfc_pkg::FLT_MS_LSB +: 2];
                fl.fifo_sel = b[canmfc_pkg::FLT_FS_LSB +: 4];
            end
        end
    end
endmodule : canmfc_filters

// ===== hdl/canmfc_top.sv
// CAN mode control and acceptance filter control, APB slave.
// Assumes a CAN engine beside it reports aborts, frames and idleness.
//
// What this block does
// RQ1 - Abort request aborts all, self-clears when done
// RQ2 - Requested mode field decoded, reserved codes
// RQ3 - Read-only mode status, same encoding
// RQ4 - Capture timer on valid receive when enabled
// RQ5 - Capture disabled halts the timer
// RQ6 - Module-on bit enables the controller
// RQ7 - Finish transaction; busy until off honoured
// RQ8 - Software polls busy after turning off
// RQ9 - Filter used only while enabled
// RQ10 - Two-bit field selects acceptance mask
// RQ11 - Five-bit field selects destination FIFO
// RQ12 - Filter bits change only while disabled
// RQ13 - Four filters, one byte each
// RQ14 - Reset: configuration mode, off, filters off
// RQ15 - Status follows request after transition done
module canmfc_top #(
    parameter int TS_W = 16
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // CAN engine status
    input  wire logic        eng_tx_pending,
    input  wire logic        eng_active,
    input  wire logic        eng_rx_valid,
    input  wire logic [3:0]  eng_id_hit,
    // CAN engine control
    output logic             tx_abort_all,
    output logic             module_enable,
    output logic [2:0]       eng_mode,
    output logic             rx_store,
    output logic [1:0]       rx_mask_sel,
    output logic [3:0]       rx_fifo_sel,
    output logic [1:0]       rx_filter_idx,
    output logic [TS_W-1:0]  rx_stamp
);
    logic             abort_r;
    logic [2:0]       requested_op_mode_r;
    logic [2:0]       opstat_r;
    logic             capen_r;
    logic             on_r;
    logic             idlest_r;
    logic             busy_r;
    logic [4:0]       dncnt_r;
    logic [TS_W-1:0]  timer_r;
    logic [TS_W-1:0]  stamp_r;
    logic [2:0]       settle_r;
    logic             rx_store_r;
    logic [1:0]       msel_r;
    logic [3:0]       fsel_r;
    logic [1:0]       fidx_r;
    logic             wr_en;
    logic             rd_en;
    logic             mapped;
    logic [31:0]      mode_word;
    canmfc_flt_if     fl ();

    canmfc_filters u_filters (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .fl      (fl)
    );

    // APB: zero wait states, unmapped addresses answer with an error
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign mapped  = paddr == canmfc_pkg::ADDR_MODE_CTRL ||
                     paddr == canmfc_pkg::ADDR_FLT_CTRL  ||
                     paddr == canmfc_pkg::ADDR_TS_TIMER  ||
                     paddr == canmfc_pkg::ADDR_TS_STAMP;
    assign pslverr = psel && penable && !mapped;
    // RQ13 filter word write
    assign fl.wdata  = pwdata;
    assign fl.we     = wr_en && paddr == canmfc_pkg::ADDR_FLT_CTRL;
    assign fl.id_hit = eng_id_hit;

    // Mode control word as seen by software
    always_comb begin
        mode_word = 32'h0000_0000;
        mode_word[canmfc_pkg::ABORT_BIT] = abort_r;
        mode_word[canmfc_pkg::REQUESTED_OP_MODE_LSB +: 3] = requested_op_mode_r;
        // RQ3 status readback
        mode_word[canmfc_pkg::STAT_LSB +: 3] = opstat_r;
        mode_word[canmfc_pkg::CAPEN_BIT] = capen_r;
        mode_word[canmfc_pkg::ON_BIT] = on_r;
        mode_word[canmfc_pkg::IDLEST_BIT] = idlest_r;
        mode_word[canmfc_pkg::BUSY_BIT] = busy_r;
        mode_word[canmfc_pkg::DNCNT_LSB +: canmfc_pkg::DNCNT_W] = dncnt_r;
    end

    // Read data is registered so it stands clean in the access phase
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                canmfc_pkg::ADDR_MODE_CTRL: prdata <= mode_word;
                canmfc_pkg::ADDR_FLT_CTRL:  prdata <= fl.cfg;
                canmfc_pkg::ADDR_TS_TIMER:  prdata <= 32'(timer_r);
                canmfc_pkg::ADDR_TS_STAMP:  prdata <= 32'(stamp_r);
                default:                    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Software-owned mode control fields
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // RQ14 reset to config
            requested_op_mode_r  <= canmfc_pkg::MODE_CONFIG;
            capen_r  <= 1'b0;
            on_r     <= 1'b0;
            idlest_r <= 1'b0;
            dncnt_r  <= 5'h00;
        end else if (wr_en && paddr == canmfc_pkg::ADDR_MODE_CTRL) begin
            requested_op_mode_r  <= pwdata[canmfc_pkg::REQUESTED_OP_MODE_LSB +: 3];
            capen_r  <= pwdata[canmfc_pkg::CAPEN_BIT];
            on_r     <= pwdata[canmfc_pkg::ON_BIT];
            idlest_r <= pwdata[canmfc_pkg::IDLEST_BIT];
            dncnt_r  <= pwdata[canmfc_pkg::DNCNT_LSB +: canmfc_pkg::DNCNT_W];
        end
    end

    // Abort request: software sets, hardware clears when drained
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            abort_r <= 1'b0;
        end else if (wr_en && paddr == canmfc_pkg::ADDR_MODE_CTRL &&
                     pwdata[canmfc_pkg::ABORT_BIT]) begin
            // RQ1 set wins over clear
            abort_r <= 1'b1;
        end else if (abort_r && !eng_tx_pending) begin
            // RQ1 cleared once drained
            abort_r <= 1'b0;
        end
    end
    // RQ1 abort broadcast
    assign tx_abort_all = abort_r;

    // Module enable: turning off waits for the engine to go idle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            module_enable <= 1'b0;
        end else if (on_r) begin
            // RQ6 enable on request
            module_enable <= 1'b1;
        end else if (!eng_active) begin
            // RQ7 finish transaction first
            module_enable <= 1'b0;
        end
    end

    // Busy while the engine works or an off request is still pending
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
        end else begin
            // RQ7 busy until honoured
            busy_r <= eng_active || (module_enable && !on_r);
        end
    end

    // Mode change: reserved codes are ignored and never reported
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            opstat_r <= canmfc_pkg::MODE_CONFIG;
            settle_r <= 3'h0;
        end else if (requested_op_mode_r == opstat_r ||
                     requested_op_mode_r == canmfc_pkg::MODE_RSVD5 ||
                     requested_op_mode_r == canmfc_pkg::MODE_RSVD6) begin
            // RQ2 reserved codes ignored
            settle_r <= 3'h0;
        end else if (eng_active) begin
            // Leaving a mode mid-frame would corrupt the bus
            settle_r <= 3'h0;
        end else if (settle_r == 3'(canmfc_pkg::MODE_SETTLE_CYC - 1)) begin
            // RQ15 status after settle
            opstat_r <= requested_op_mode_r;
            settle_r <= 3'h0;
        end else begin
            settle_r <= settle_r + 3'h1;
        end
    end
    // RQ2 decoded mode to engine
    assign eng_mode = opstat_r;

    // Timestamp timer runs only while capture is enabled
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timer_r <= '0;
        end else if (capen_r) begin
            timer_r <= timer_r + TS_W'(1);
        end
        // RQ5 timer halts otherwise
    end

    // Capture, while capture is enabled, on each valid reception that a live filter accepts
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stamp_r <= '0;
        end else if (capen_r && eng_rx_valid && fl.match) begin
            // RQ4 capture with message
            stamp_r <= timer_r;
        end
    end

    // Register the acceptance result alongside the stamp
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rx_store_r <= 1'b0;
            msel_r     <= 2'd0;
            fsel_r     <= 4'd0;
            fidx_r     <= 2'd0;
        end else begin
            // RQ9 only live filters
            rx_store_r <= eng_rx_valid && fl.match && module_enable;
            // RQ10 mask choice
            msel_r     <= fl.mask_sel;
            // RQ11 FIFO choice
            fsel_r     <= fl.fifo_sel;
            fidx_r     <= fl.flt_idx;
        end
    end
    assign rx_store      = rx_store_r;
    assign rx_mask_sel   = msel_r;
    assign rx_fifo_sel   = fsel_r;
    assign rx_filter_idx = fidx_r;
    assign rx_stamp      = stamp_r;
endmodule : canmfc_top

// ===== verification/canmfc_top_asserts.sv
// Checker for the CAN mode and filter control block.
// Sees only top-level ports; bound in from the bench file.
module canmfc_top_asserts #(
    parameter int TS_W = 16
) (
    // Clock, reset and bus strobes
    input wire logic            ref_clk,
    input wire logic            sys_rst,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    // Engine status
    input wire logic            eng_tx_pending,
    input wire logic            eng_active,
    input wire logic            eng_rx_valid,
    input wire logic [3:0]      eng_id_hit,
    // Engine control
    input wire logic            tx_abort_all,
    input wire logic            module_enable,
    input wire logic [2:0]      eng_mode,
    input wire logic            rx_store,
    input wire logic [1:0]      rx_filter_idx,
    input wire logic [TS_W-1:0] rx_stamp
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Bus write excluded: a new abort request wins over the clear
    a_abort_clear: assert property (
        tx_abort_all && !eng_tx_pending && !(psel && penable && pwrite)
        |=> !tx_abort_all) else $error("abort bit not cleared");
    a_abort_hold: assert property (
        tx_abort_all && eng_tx_pending |=> tx_abort_all)
        else $error("abort dropped while pending");
    a_reset_cfg: assert property (
        $fell(sys_rst) |-> eng_mode == canmfc_pkg::MODE_CONFIG
        && !module_enable && !tx_abort_all) else $error("bad reset state");
    a_mode_idle: assert property (
        $changed(eng_mode) && !$past(sys_rst) |-> !$past(eng_active)
        && !$past(eng_active, 2) && !$past(eng_active, 3))
        else $error("mode moved while engine busy");
    a_no_reserved: assert property (
        !(eng_mode inside {3'h5, 3'h6})) else $error("reserved mode shown");
    a_off_wait: assert property (
        module_enable && eng_active |=> module_enable)
        else $error("disabled mid transaction");
    a_store_cause: assert property (
        rx_store |-> $past(eng_rx_valid) && $past(module_enable)
        && ((($past(eng_id_hit)) >> rx_filter_idx) & 4'h1) != 4'h0)
        else $error("store without cause");
    a_no_hit: assert property (
        eng_rx_valid && eng_id_hit == 4'h0 |=> !rx_store)
        else $error("store without filter hit");
    a_stamp_cause: assert property (
        $changed(rx_stamp) && !$past(sys_rst) |-> rx_store)
        else $error("stamp moved without store");

    // Main scenarios reached
    c_store: cover property (rx_store);
    c_abort: cover property ($fell(tx_abort_all));
    c_off: cover property ($fell(module_enable));
endmodule : canmfc_top_asserts

// ===== verification/canmfc_can_node.sv
// Behavioural CAN engine standing beside the block.
// Bench commands frames and pending transmissions.
module canmfc_can_node (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    // From the block and the bench
    input wire logic       tx_abort_all,
    input wire logic       load_tx,
    input wire logic       rx_go,
    input wire logic [7:0] act_len,
    input wire logic [3:0] hit,
    // To the block
    output logic           eng_tx_pending,
    output logic           eng_rx_valid,
    output logic           eng_active,
    output logic [3:0]     eng_id_hit
);
    logic [7:0] cnt_r;
    logic [2:0] ab_r;

    // abort takes several cycles, slow on purpose
    always_ff @(posedge ref_clk) begin
        if (sys_rst || load_tx) begin
            eng_tx_pending <= load_tx;
            ab_r <= 3'h0;
        end else if (tx_abort_all && eng_tx_pending) begin
            ab_r <= ab_r + 3'h1;
            eng_tx_pending <= (ab_r != 3'h5);
        end
    end

    // frame busy for act_len cycles, then valid
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_r <= 8'h00;
            eng_rx_valid <= 1'b0;
        end else begin
            eng_rx_valid <= (cnt_r == 8'h01);
            cnt_r <= rx_go ? act_len : cnt_r - {7'h00, cnt_r != 8'h00};
        end
    end
    assign eng_active = (cnt_r != 8'h00);
    // Hit lines only meaningful with valid; garbage otherwise
    assign eng_id_hit = eng_rx_valid ? hit : ~hit;
endmodule : canmfc_can_node

// ===== verification/canmfc_top_tb.sv
// Self-checking bench for the CAN mode and filter control block.
// APB from the bench, engine side from the node model.
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, g, e); end end
module canmfc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TS_W = 16;
    localparam logic [31:0] CFG = 32'hefc3_ad8c;
    localparam logic [2:0] REQ [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                       3'h7, 3'h5, 3'h6, 3'h4};
    localparam logic [2:0] EXP [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                       3'h7, 3'h7, 3'h7, 3'h4};
    logic ref_clk = 1'b0, sys_rst = 1'b1, ld = 1'b0, go = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, len = 8'h04;
    logic [31:0] pwdata = 32'h0, prdata, q, t1;
    logic [3:0] hit = 4'h0, id_hit, fs;
    logic pready, pslverr, e, got, tx_pend, eng_act, rx_v, abort, men, st;
    logic [2:0] eng_mode;
    logic [1:0] ms, idx;
    logic [8:0] xp;
    logic [TS_W-1:0] stamp;
    int num_errors = 0, tests_run = 0;

    // Design and far-side engine
    canmfc_top #(.TS_W(TS_W)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .eng_tx_pending(tx_pend),
        .eng_active(eng_act), .eng_rx_valid(rx_v), .eng_id_hit(id_hit),
        .tx_abort_all(abort), .module_enable(men), .eng_mode(eng_mode),
        .rx_store(st), .rx_mask_sel(ms), .rx_fifo_sel(fs),
        .rx_filter_idx(idx), .rx_stamp(stamp));
    canmfc_can_node i_node (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .tx_abort_all(abort), .load_tx(ld), .rx_go(go), .act_len(len),
        .hit(hit), .eng_tx_pending(tx_pend), .eng_active(eng_act),
        .eng_rx_valid(rx_v), .eng_id_hit(id_hit));

    always #2 ref_clk = ~ref_clk;

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // One APB transfer; request held until pready seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Frame with given hits; got tells whether it was stored
    task automatic rx(input logic [3:0] h);
        hit <= h;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        got = 1'b0;
        for (int n = 0; n < 16 && !got; n++) begin
            @(posedge ref_clk);
            got = (st === 1'b1);
        end
    endtask : rx

    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        `CHK(q, 32'h0480_0000)
        // Every mode code; reserved ones must not move the status
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 8'h00, {5'h00, REQ[i], 24'h0});
            for (int n = 0; n < 40 && eng_mode !== EXP[i]; n++)
                @(posedge ref_clk);
            repeat (8) @(posedge ref_clk);
            apb(1'b0, 8'h00, 32'h0);
            `CHK(q[23:21], EXP[i])
            `CHK(eng_mode, EXP[i])
            $display("mode row %0d done", i);
        end
        // Module on with capture; disabled filters never store
        apb(1'b1, 8'h00, 32'h0410_8000);
        apb(1'b1, 8'h04, 32'h6f4e_2d0c);
        rx(4'hf);
        `CHK(got, 1'b0)
        apb(1'b1, 8'h04, CFG);
        apb(1'b1, 8'h04, 32'hffff_ffff);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(q, CFG)
        apb(1'b0, 8'h08, 32'h0);
        t1 = q;
        for (int i = 0; i < 4; i++) begin
            rx(4'h1 << i);
            // Expected hit, index, mask and FIFO from the filter byte
            xp = {1'b1, i[1:0], CFG[8*i+5 +: 2], CFG[8*i +: 4]};
            `CHK({got, idx, ms, fs}, xp)
            `CHK(stamp > t1[TS_W-1:0], 1'b1)
            t1 = {16'h0, stamp};
        end
        $display("filter test done");
        // Capture off: timer and stamp frozen
        apb(1'b1, 8'h00, 32'h0400_8000);
        apb(1'b0, 8'h08, 32'h0);
        t1 = q;
        repeat (5) @(posedge ref_clk);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(q, t1)
        t1 = {16'h0, stamp};
        rx(4'h1);
        `CHK({got, stamp}, {1'b1, t1[TS_W-1:0]})
        // Unlock filter 0, give it a reserved FIFO code; filter 1 takes it
        apb(1'b1, 8'h04, {CFG[31:8], 8'h0c});
        apb(1'b1, 8'h04, {CFG[31:8], 8'h90});
        apb(1'b0, 8'h04, 32'h0);
        `CHK(q[7:0], 8'h90)
        rx(4'h3);
        `CHK({got, idx}, {1'b1, 2'h1})
        $display("reserved fifo test done");
        // Abort stays set while a transmission is pending
        ld <= 1'b1;
        @(posedge ref_clk);
        ld <= 1'b0;
        apb(1'b1, 8'h00, 32'h0c00_8000);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(q[27], 1'b1)
        for (int n = 0; n < 40 && abort !== 1'b0; n++)
            @(posedge ref_clk);
        apb(1'b0, 8'h00, 32'h0);
        `CHK({q[27], abort, tx_pend}, 3'b000)
        $display("abort test done");
        // Turn off mid-frame; busy polled until honoured
        hit <= 4'h0;
        len <= 8'h1e;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        apb(1'b1, 8'h00, 32'h0400_0000);
        apb(1'b0, 8'h00, 32'h0);
        `CHK({q[11], men}, 2'b11)
        for (int n = 0; n < 40 && q[11] !== 1'b0; n++)
            apb(1'b0, 8'h00, 32'h0);
        `CHK({q[11], eng_act, men}, 3'b000)
        apb(1'b0, 8'h40, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        $display("off and unmapped test done");
        // Reset in mid-run
        sys_rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        `CHK(q, 32'h0480_0000)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(q, 32'h0)
        $display("reset test done");
        end_of_test();
    end
endmodule : canmfc_top_tb

bind canmfc_top canmfc_top_asserts #(.TS_W(TS_W)) u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .eng_tx_pending(eng_tx_pending),
    .eng_active(eng_active), .eng_rx_valid(eng_rx_valid),
    .eng_id_hit(eng_id_hit), .tx_abort_all(tx_abort_all),
    .module_enable(module_enable), .eng_mode(eng_mode),
    .rx_store(rx_store), .rx_filter_idx(rx_filter_idx),
    .rx_stamp(rx_stamp));
